// File: core/tcpc_pkg.sv
package tcpc_pkg;
  // Register indices
  localparam logic [7:0] TCPC_CLK_MOD_CFG = 8'h00;
  localparam logic [7:0] TCPC_CO_BAUD_CFG = 8'h01;
  localparam logic [7:0] TCPC_BAUD_PRE_CFG = 8'h02;
  localparam logic [7:0] TCPC_POWER_CFG = 8'h03;
  // Reset values
  localparam logic [7:0] TCPC_CLK_MOD_RST = 8'h90;
  localparam logic [7:0] TCPC_CO_BAUD_RST = 8'h81;
  localparam logic [7:0] TCPC_BAUD_PRE_RST = 8'h03;
  localparam logic [7:0] TCPC_POWER_RST = 8'h00;
  // Field positions
  localparam int TCPC_XTAL_DLY_LSB = 6;
  localparam int TCPC_CORE_DIV_LSB = 4;
  localparam int TCPC_SHAPE_BIT = 2;
  localparam int TCPC_SYNC_BIT = 1;
  localparam int TCPC_MOD_BIT = 0;
  localparam int TCPC_CO_DLY_LSB = 6;
  // Readable bit masks, reserved bits read zero
  localparam logic [7:0] TCPC_CLK_MOD_MASK = 8'hF7;
  localparam logic [7:0] TCPC_CO_BAUD_MASK = 8'hC7;
  localparam logic [7:0] TCPC_POWER_MASK = 8'h03;
  // Timing counts in crystal and divided-clock cycles
  localparam logic [6:0] TCPC_XTAL_DLY_UNIT = 7'h08;
  localparam logic [9:0] TCPC_CO_DLY_BASE = 10'h040;
  localparam logic [2:0] TCPC_CORE_DIV_BASE = 3'h4;
  localparam logic [7:0] TCPC_PRE_MIN = 8'h03;
  localparam logic [2:0] TCPC_POST_MIN = 3'h1;
  localparam logic [2:0] TCPC_POST_MAX = 3'h5;
  // Low-power select codes
  localparam logic [1:0] TCPC_LP_SHUTDOWN = 2'h0;
  localparam logic [1:0] TCPC_LP_STANDBY = 2'h1;
  localparam logic [1:0] TCPC_LP_FAST = 2'h2;
  // Serial slave address, value arbitrary
  localparam logic [6:0] TCPC_DEV_ADDR = 7'h2A;
  localparam logic [3:0] TCPC_BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {
    TCPC_PS_ACTIVE, TCPC_PS_SHUT, TCPC_PS_STBY, TCPC_PS_FAST
  } tcpc_pstate_t;

  typedef enum logic [3:0] {
    TCPC_I_IDLE, TCPC_I_ADDR, TCPC_I_ACKA, TCPC_I_PTR, TCPC_I_ACKP,
    TCPC_I_WR, TCPC_I_ACKW, TCPC_I_RD, TCPC_I_MACK
  } tcpc_istate_t;
endpackage : tcpc_pkg

// File: core/tcpc_top.sv
module tcpc_top (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  // Serial register port, open drain data
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  // Transmit sequencing
  input wire logic PKT_DONE_I,
  input wire logic WAKE_I,
  // Clock output pin and data pin
  input wire logic CLK_PIN_I,
  output logic CLK_PIN_O,
  output logic CLK_PIN_OE_N_O,
  input wire logic DATA_I,
  output logic SAMPLED_DATA_O,
  // Clocks and controls to the radio
  output logic CORE_CLK_O,
  output logic BAUD_TICK_O,
  output logic MOD_FSK_O,
  output logic SHAPE_EN_O,
  output logic XTAL_EN_O,
  output logic PLL_EN_O,
  output logic PA_EN_O
);
  import tcpc_pkg::*;

  logic [7:0] cfg_clk_q, cfg_co_q, cfg_pre_q, cfg_pwr_q;
  logic wr_q;
  logic [7:0] wr_addr_q, wr_data_q;
  tcpc_istate_t ist_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, tx_q, ptr_q;
  logic rw_q, nack_q, scl_q, sda_q, sda_oe_n_q;
  logic [7:0] rd_data;
  tcpc_pstate_t ps_q;
  logic leave_shut;
  logic [6:0] xtal_cnt_q, xtal_tgt;
  logic core_run_q;
  logic [2:0] dcnt_q, ratio, high_t;
  logic core_clk_q, core_rise;
  logic [9:0] co_cnt_q, co_tgt;
  logic co_en_q;
  logic [7:0] pre_cnt_q, pre_div;
  logic [2:0] post_cnt_q, post_div;
  logic baud_q, clk_pin_q, sample_q, co_pin_q, co_oe_n_q;
  logic xtal_en_q, pll_en_q, pa_en_q;

  // ************************
  // Serial register port
  // ************************
  always_comb begin
    unique case (ptr_q)
      TCPC_CLK_MOD_CFG: rd_data = cfg_clk_q;
      TCPC_CO_BAUD_CFG: rd_data = cfg_co_q;
      TCPC_BAUD_PRE_CFG: rd_data = cfg_pre_q;
      TCPC_POWER_CFG: rd_data = cfg_pwr_q;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ist_q <= TCPC_I_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      wr_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
      wr_q <= 1'b0;
      if (scl_q && SCL_I && sda_q && !SDA_I) begin
        ist_q <= TCPC_I_ADDR;
        bit_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end else if (scl_q && SCL_I && !sda_q && SDA_I) begin
        ist_q <= TCPC_I_IDLE;
        sda_oe_n_q <= 1'b1;
      end else if (!scl_q && SCL_I) begin
        sh_q <= {sh_q[6:0], SDA_I};
        bit_q <= bit_q + 4'h1;
        if (ist_q == TCPC_I_MACK) begin
          nack_q <= SDA_I;
        end
      end else if (scl_q && !SCL_I) begin
        unique case (ist_q)
          TCPC_I_ADDR: begin
            if (bit_q == TCPC_BYTE_BITS) begin
              if (sh_q[7:1] == TCPC_DEV_ADDR) begin
                rw_q <= sh_q[0];
                ist_q <= TCPC_I_ACKA;
                sda_oe_n_q <= 1'b0;
              end else begin
                ist_q <= TCPC_I_IDLE;
              end
            end
          end
          TCPC_I_ACKA, TCPC_I_MACK: begin
            bit_q <= 4'h0;
            if (ist_q == TCPC_I_MACK && nack_q) begin
              ist_q <= TCPC_I_IDLE;
              sda_oe_n_q <= 1'b1;
            end else if (rw_q) begin
              tx_q <= rd_data;
              sda_oe_n_q <= rd_data[7];
              ptr_q <= ptr_q + 8'h01;
              ist_q <= TCPC_I_RD;
            end else begin
              sda_oe_n_q <= 1'b1;
              ist_q <= TCPC_I_PTR;
            end
          end
          TCPC_I_PTR, TCPC_I_WR: begin
            if (bit_q == TCPC_BYTE_BITS) begin
              sda_oe_n_q <= 1'b0;
              if (ist_q == TCPC_I_PTR) begin
                ptr_q <= sh_q;
                ist_q <= TCPC_I_ACKP;
              end else begin
                wr_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= sh_q;
                ptr_q <= ptr_q + 8'h01;
                ist_q <= TCPC_I_ACKW;
              end
            end
          end
          TCPC_I_ACKP, TCPC_I_ACKW: begin
            sda_oe_n_q <= 1'b1;
            bit_q <= 4'h0;
            ist_q <= TCPC_I_WR;
          end
          TCPC_I_RD: begin
            if (bit_q == TCPC_BYTE_BITS) begin
              sda_oe_n_q <= 1'b1;
              ist_q <= TCPC_I_MACK;
            end else begin
              sda_oe_n_q <= tx_q[3'h7 - bit_q[2:0]];
            end
          end
          default: begin
            sda_oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // ************************
  // Configuration registers
  // ************************
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cfg_clk_q <= TCPC_CLK_MOD_RST;
      cfg_co_q <= TCPC_CO_BAUD_RST;
      cfg_pre_q <= TCPC_BAUD_PRE_RST;
      cfg_pwr_q <= TCPC_POWER_RST;
    end else if (wr_q) begin
      unique case (wr_addr_q)
        TCPC_CLK_MOD_CFG: cfg_clk_q <= wr_data_q & TCPC_CLK_MOD_MASK;
        TCPC_CO_BAUD_CFG: cfg_co_q <= wr_data_q & TCPC_CO_BAUD_MASK;
        TCPC_BAUD_PRE_CFG: cfg_pre_q <= wr_data_q;
        TCPC_POWER_CFG: cfg_pwr_q <= wr_data_q & TCPC_POWER_MASK;
        default: ;
      endcase
    end
  end

  // ************************
  // Power state
  // ************************
  assign leave_shut = (ps_q == TCPC_PS_SHUT) && WAKE_I;

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ps_q <= TCPC_PS_ACTIVE;
    end else if (ps_q == TCPC_PS_ACTIVE) begin
      if (PKT_DONE_I) begin
        unique case (cfg_pwr_q[1:0])
          TCPC_LP_SHUTDOWN: ps_q <= TCPC_PS_SHUT;
          TCPC_LP_STANDBY: ps_q <= TCPC_PS_STBY;
          default: ps_q <= TCPC_PS_FAST;
        endcase
      end
    end else if (WAKE_I) begin
      ps_q <= TCPC_PS_ACTIVE;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      xtal_en_q <= 1'b1;
      pll_en_q <= 1'b1;
      pa_en_q <= 1'b1;
    end else begin
      xtal_en_q <= ps_q != TCPC_PS_SHUT;
      pll_en_q <= (ps_q == TCPC_PS_ACTIVE) || (ps_q == TCPC_PS_FAST);
      pa_en_q <= ps_q == TCPC_PS_ACTIVE;
    end
  end

  // ************************
  // Core clock
  // ************************
  assign xtal_tgt = (cfg_clk_q[7:6] == 2'h0) ? 7'h00 :
                    7'(TCPC_XTAL_DLY_UNIT << cfg_clk_q[7:6]);
  assign ratio = TCPC_CORE_DIV_BASE + {1'b0, cfg_clk_q[5:4]};
  assign high_t = ratio >> 1;
  assign core_rise = core_run_q && (dcnt_q == 3'h0);

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      xtal_cnt_q <= 7'h00;
      core_run_q <= 1'b0;
    end else if (ps_q == TCPC_PS_SHUT || leave_shut) begin
      xtal_cnt_q <= 7'h00;
      core_run_q <= 1'b0;
    end else if (!core_run_q) begin
      if (xtal_cnt_q >= xtal_tgt) begin
        core_run_q <= 1'b1;
      end else begin
        xtal_cnt_q <= xtal_cnt_q + 7'h01;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dcnt_q <= 3'h0;
      core_clk_q <= 1'b0;
    end else if (!core_run_q) begin
      dcnt_q <= 3'h0;
      core_clk_q <= 1'b0;
    end else begin
      dcnt_q <= (dcnt_q >= ratio - 3'h1) ? 3'h0 : dcnt_q + 3'h1;
      core_clk_q <= dcnt_q < high_t;
    end
  end

  // ************************
  // Clock output and sampling
  // ************************
  assign co_tgt = 10'(TCPC_CO_DLY_BASE << cfg_co_q[7:6]);

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      co_cnt_q <= 10'h000;
      co_en_q <= 1'b0;
    end else if (ps_q == TCPC_PS_SHUT || leave_shut) begin
      co_cnt_q <= 10'h000;
      co_en_q <= 1'b0;
    end else if (!co_en_q && core_rise) begin
      if (co_cnt_q >= co_tgt - 10'h001) begin
        co_en_q <= 1'b1;
      end
      co_cnt_q <= co_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      clk_pin_q <= 1'b0;
      sample_q <= 1'b0;
      co_pin_q <= 1'b0;
      co_oe_n_q <= 1'b1;
    end else begin
      clk_pin_q <= CLK_PIN_I;
      co_oe_n_q <= cfg_clk_q[TCPC_SYNC_BIT];
      co_pin_q <= co_en_q && core_clk_q && !cfg_clk_q[TCPC_SYNC_BIT];
      if (cfg_clk_q[TCPC_SYNC_BIT] && CLK_PIN_I && !clk_pin_q) begin
        sample_q <= DATA_I;
      end
    end
  end

  // ************************
  // Baud clock
  // ************************
  // Reserved codes select the minimum divide (pre 3, post 1)
  assign pre_div = (cfg_pre_q < TCPC_PRE_MIN) ? TCPC_PRE_MIN : cfg_pre_q;
  assign post_div = (cfg_co_q[2:0] < TCPC_POST_MIN ||
                     cfg_co_q[2:0] > TCPC_POST_MAX) ? TCPC_POST_MIN :
                    cfg_co_q[2:0];

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pre_cnt_q <= 8'h00;
      post_cnt_q <= 3'h0;
      baud_q <= 1'b0;
    end else begin
      baud_q <= 1'b0;
      if (core_rise) begin
        if (pre_cnt_q >= pre_div - 8'h01) begin
          pre_cnt_q <= 8'h00;
          if (post_cnt_q >= post_div - 3'h1) begin
            post_cnt_q <= 3'h0;
            baud_q <= 1'b1;
          end else begin
            post_cnt_q <= post_cnt_q + 3'h1;
          end
        end else begin
          pre_cnt_q <= pre_cnt_q + 8'h01;
        end
      end
    end
  end

  // ************************
  // Outputs
  // ************************
  assign SDA_O = 1'b0;
  assign SDA_OE_N_O = sda_oe_n_q;
  assign CLK_PIN_O = co_pin_q;
  assign CLK_PIN_OE_N_O = co_oe_n_q;
  assign SAMPLED_DATA_O = sample_q;
  assign CORE_CLK_O = core_clk_q;
  assign BAUD_TICK_O = baud_q;
  assign MOD_FSK_O = cfg_clk_q[TCPC_MOD_BIT];
  assign SHAPE_EN_O = cfg_clk_q[TCPC_SHAPE_BIT];
  assign XTAL_EN_O = xtal_en_q;
  assign PLL_EN_O = pll_en_q;
  assign PA_EN_O = pa_en_q;

  // ************************
  // Assertions
  // ************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_high5;
    core_clk_q [*2];
  endsequence
  sequence s_low5;
    !core_clk_q [*3];
  endsequence

  div_five_a: assert property (
    ($rose(core_clk_q) && ratio == 3'h5 && $stable(cfg_clk_q) &&
     core_run_q) |-> s_high5 ##1 s_low5 or !core_run_q [*1])
    else $error("divide by five duty wrong");
  div_seven_a: assert property (
    ($rose(core_clk_q) && ratio == 3'h7 && $stable(cfg_clk_q))
    |-> core_clk_q [*3] ##1 !core_clk_q [*4] or ##[0:6] !core_run_q)
    else $error("divide by seven duty wrong");
  xtal_delay_a: assert property (
    $rose(core_run_q) |-> $past(xtal_cnt_q) == xtal_tgt)
    else $error("core clock released at wrong count");
  co_delay_a: assert property (
    $rose(co_en_q) |-> co_cnt_q == co_tgt)
    else $error("clock output started at wrong count");
  shutdown_pwr_a: assert property (
    (ps_q == TCPC_PS_ACTIVE && PKT_DONE_I && cfg_pwr_q[1:0] == 2'h0)
    |=> ps_q == TCPC_PS_SHUT ##1 !xtal_en_q && !pll_en_q && !pa_en_q)
    else $error("shutdown state not entered");
  standby_pwr_a: assert property (
    ps_q == TCPC_PS_STBY |=> xtal_en_q && !pll_en_q && !pa_en_q)
    else $error("standby enables wrong");
  fast_revert_a: assert property (
    (ps_q == TCPC_PS_ACTIVE && PKT_DONE_I && cfg_pwr_q[1])
    |=> ps_q == TCPC_PS_FAST ##1 xtal_en_q && pll_en_q && !pa_en_q)
    else $error("fast wakeup not chosen");
  sync_pin_a: assert property (
    cfg_clk_q[TCPC_SYNC_BIT] |=> CLK_PIN_OE_N_O && !CLK_PIN_O)
    else $error("clock pin driven while sampling");
  baud_tick_a: assert property (
    BAUD_TICK_O |-> pre_cnt_q == 8'h00 && post_cnt_q == 3'h0 &&
    $past(core_rise))
    else $error("baud tick without divider wrap");
endmodule : tcpc_top

// File: verif/tcpc_host_model.sv
module tcpc_host_model (
  // Clock and device pull
  input wire logic clk_i,
  input wire logic dev_oe_n_i,
  // Serial bus
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import tcpc_pkg::*;

  logic pull_q = 1'b0;
  logic scl_q = 1'b1;

  // Pull-up: released line reads high
  assign sda_o = ~pull_q & dev_oe_n_i;
  assign scl_o = scl_q;

  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask : half

  task automatic start();
    pull_q = 1'b0;
    scl_q = 1'b1;
    half();
    pull_q = 1'b1;
    half();
    scl_q = 1'b0;
  endtask : start

  task automatic stop();
    @(negedge clk_i);
    pull_q = 1'b1;
    half();
    scl_q = 1'b1;
    half();
    pull_q = 1'b0;
    half();
  endtask : stop

  task automatic bit_io(input logic b, output logic r);
    @(negedge clk_i);
    pull_q = ~b;
    half();
    scl_q = 1'b1;
    half();
    r = sda_o;
    scl_q = 1'b0;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_io

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d,
                        output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    ok = 1'b0;
    if ((idx == 8'h02 && d < TCPC_PRE_MIN) || (idx == 8'h01 &&
        (d[2:0] < TCPC_POST_MIN || d[2:0] > TCPC_POST_MAX))) begin
      return;
    end
    start();
    byte_io({TCPC_DEV_ADDR, 1'b0}, rx, a0);
    byte_io(idx, rx, a1);
    byte_io(d, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
    logic [7:0] rx;
    logic a;
    start();
    byte_io({TCPC_DEV_ADDR, 1'b0}, rx, a);
    byte_io(idx, rx, a);
    stop();
    start();
    byte_io({TCPC_DEV_ADDR, 1'b1}, rx, a);
    byte_io(8'hFF, d, a);
    stop();
  endtask : rd_reg
endmodule : tcpc_host_model

// File: verif/tx_clock_power_config_bench.sv
module tx_clock_power_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tcpc_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pkt = 1'b0;
  logic wake = 1'b0;
  logic cpin = 1'b0;
  logic din = 1'b0;
  logic scl, sda, sda_oe_n, cpin_o, cpin_oe_n, samp;
  logic core, tick, fsk, shape, xtal, pll, pa;
  int errors = 0;
  int total_checks = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  tcpc_host_model u_host (.clk_i(clk), .dev_oe_n_i(sda_oe_n),
    .scl_o(scl), .sda_o(sda));

  tcpc_top u_dut (
    .SYS_CLK_I(clk), .ARST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(), .SDA_OE_N_O(sda_oe_n), .PKT_DONE_I(pkt), .WAKE_I(wake),
    .CLK_PIN_I(cpin), .CLK_PIN_O(cpin_o), .CLK_PIN_OE_N_O(cpin_oe_n),
    .DATA_I(din), .SAMPLED_DATA_O(samp), .CORE_CLK_O(core),
    .BAUD_TICK_O(tick), .MOD_FSK_O(fsk), .SHAPE_EN_O(shape),
    .XTAL_EN_O(xtal), .PLL_EN_O(pll), .PA_EN_O(pa));

  // ************
  // Helpers
  // ************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a;
    u_host.wr_reg(idx, d, a);
    chk({15'h0, a}, 16'h1);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd_reg(idx, d);
    chk({8'h0, d}, {8'h0, exp});
  endtask : rd

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  task automatic pulse(ref logic s, input int w);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    wait_n(w);
  endtask : pulse

  task automatic span(input logic v, output int n);
    n = 0;
    while (core === v && n < 4000) begin
      @(negedge clk);
      n++;
    end
  endtask : span

  task automatic tick_gap(output int n);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (tick !== 1'b1 && n < 4000);
    end
  endtask : tick_gap

  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ************
  // Tests
  // ************
  initial begin : main
    int hi, lo, n, t1, t2, xd, cd;
    logic a;
    logic [7:0] v;
    int pre_t[3] = '{3, 7, 255};
    int post_t[3] = '{1, 5, 3};
    logic [15:0] pw_t[4] = '{16'h0, 16'h4, 16'h6, 16'h6};
    wait_n(5);
    rst_n = 1'b1;
    chk({13'h0, xtal, pll, pa}, 16'h7);
    rd(8'h00, 8'h90);
    rd(8'h01, 8'h81);
    rd(8'h02, 8'h03);
    rd(8'h03, 8'h00);
    rd(8'h05, 8'h00);
    u_host.start();
    u_host.byte_io(8'hA0, v, a);
    u_host.stop();
    chk({15'h0, a}, 16'h0);
    $display("test regs done");
    for (int m = 0; m < 4; m++) begin
      v = {4'h9, 1'b0, m[1], 1'b0, m[0]};
      wr(8'h00, v);
      chk({14'h0, shape, fsk}, m[15:0]);
      rd(8'h00, v);
    end
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'hF7);
    $display("test modulation done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, {2'h2, c[1:0], 4'h0});
      span(1'b1, n);
      span(1'b0, n);
      span(1'b1, hi);
      span(1'b0, lo);
      chk(16'(hi + lo), 16'(4 + c));
      if (c % 2 == 1) chk(16'(hi), 16'((c + 3) / 2));
    end
    $display("test divider done");
    wr(8'h00, 8'h80);
    for (int i = 0; i < 3; i++) begin
      wr(8'h02, 8'(pre_t[i]));
      wr(8'h01, {5'h10, 3'(post_t[i])});
      tick_gap(n);
      chk(16'(n), 16'(pre_t[i] * post_t[i] * 4));
    end
    $display("test baud done");
    wr(8'h00, 8'h82);
    chk({15'h0, cpin_oe_n}, 16'h1);
    for (int b = 1; b >= 0; b--) begin
      din = b[0];
      wait_n(2);
      cpin = 1'b1;
      wait_n(4);
      chk({15'h0, samp}, 16'(b));
      cpin = 1'b0;
      wait_n(4);
    end
    wr(8'h00, 8'h80);
    chk({15'h0, cpin_oe_n}, 16'h0);
    $display("test sampling done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h03, 8'(c));
      pulse(pkt, 3);
      chk({13'h0, xtal, pll, pa}, pw_t[c]);
      pulse(wake, 3);
      chk({13'h0, xtal, pll, pa}, 16'h7);
    end
    $display("test power done");
    wr(8'h03, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, {c[1:0], 6'h00});
      wr(8'h01, {c[1:0], 6'h01});
      pulse(pkt, 3);
      pulse(wake, 0);
      t1 = -1;
      t2 = -1;
      for (int i = 0; i < 3000 && t2 < 0; i++) begin
        @(negedge clk);
        if (t1 < 0 && core === 1'b1) t1 = i;
        if (cpin_o === 1'b1) t2 = i;
      end
      xd = (c == 0) ? 0 : (8 << c);
      cd = (64 << c) * 4;
      chk(16'(t1 >= xd - 1 && t1 <= xd + 8), 16'h1);
      chk(16'(t2 - t1 >= cd - 4 && t2 - t1 <= cd + 8), 16'h1);
    end
    $display("test delays done");
    test_done();
  end

  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule : tx_clock_power_config_bench
